// file: core/dtl_regs.svh
// Register offsets, field positions, reset values and timing figures for the DPLL/host-port config bank.
// Assumes a 12-bit byte address from the paged host port and 8-bit data.
`ifndef DTL_REGS_SVH
`define DTL_REGS_SVH
`define DTL_ADDR_W 12
`define DTL_DATA_W 8
`define DTL_OFS_SPLIT 12'h623
`define DTL_OFS_CLRSW 12'h624
`define DTL_OFS_THRESH 12'h625
`define DTL_OFS_LOCKDLY 12'h638
`define DTL_OFS_GUARD 12'h67e
`define DTL_RST_VAL 8'h00
`define DTL_BIT_EN 0
`define DTL_BIT_LOCKOUT 7
`define DTL_BIT_FAIL 0
`define DTL_THRESH_STEP_NS 10
`define DTL_CLK_PERIOD_NS 4
`define DTL_N_REGS 5
`define DTL_IDX_W 3
`define DTL_IDX_SPLIT 3'h0
`define DTL_IDX_CLRSW 3'h1
`define DTL_IDX_THRESH 3'h2
`define DTL_IDX_LOCKDLY 3'h3
`define DTL_IDX_GUARD 3'h4
`define DTL_PHASE_W 16
`endif

// file: core/dtl_pkg.sv
// Types shared by the config bank, its checks, its host model and its test bench.
// Assumes dtl_regs.svh is on the include path.
`include "dtl_regs.svh"
package dtl_pkg;
  // One host access request
  typedef struct packed {
    logic valid;
    logic write;
    logic [`DTL_ADDR_W-1:0] addr;
    logic [`DTL_DATA_W-1:0] wdata;
  } dtl_req_t;
  // One host access answer
  typedef struct packed {
    logic valid;
    logic fail;
    logic [`DTL_DATA_W-1:0] rdata;
  } dtl_rsp_t;
  // DPLL loop events seen by the bank
  typedef struct packed {
    logic ref_switch;
    logic mode_to_ref;
    logic tie_clear_bit;
    logic tie_write_active;
    logic [`DTL_PHASE_W-1:0] align_err_ns;
  } dtl_dpll_t;
  // Access decoder states
  typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} dtl_state_t;
endpackage

// file: core/dtl_regmem.sv
// Small register store with registered read data.
// Assumes writes and reads are pre-decoded to a valid index by the bank.
`timescale 1ns/1ns
`include "dtl_regs.svh"
module dtl_regmem (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire logic we_in,
  input wire logic [`DTL_IDX_W-1:0] widx_in,
  input wire logic [`DTL_DATA_W-1:0] wdata_in,
  input wire logic [`DTL_IDX_W-1:0] ridx_in,
  output logic [`DTL_DATA_W-1:0] rdata_out,
  output logic [`DTL_N_REGS*`DTL_DATA_W-1:0] all_out
);
  logic [`DTL_DATA_W-1:0] mem_q [`DTL_N_REGS]; // Register words
  genvar gi;
  // One word per register, all reset to zero
  generate
    for (gi = 0; gi < `DTL_N_REGS; gi++) begin : g_word
      always_ff @(posedge clk_sys_in) begin
        if (sys_rst_in) begin
          mem_q[gi] <= `DTL_RST_VAL;
        end else if (we_in && (widx_in == `DTL_IDX_W'(gi))) begin
          mem_q[gi] <= wdata_in;
        end
      end
      assign all_out[gi*`DTL_DATA_W +: `DTL_DATA_W] = mem_q[gi];
    end
  endgenerate
  // Registered read port
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      rdata_out <= `DTL_RST_VAL;
    end else begin
      rdata_out <= (ridx_in < `DTL_N_REGS) ? mem_q[ridx_in] : `DTL_RST_VAL;
    end
  end
endmodule // dtl_regmem

// file: core/dtl_bank.sv
// DPLL TIE, lock-delay and host-port guard configuration bank.
// Assumes the host port deserialiser delivers whole byte accesses as one-cycle requests in clk_sys_in.
// Assumes the DPLL event inputs are one-cycle pulses and its levels are already in this clock domain.
`timescale 1ns/1ns
`include "dtl_regs.svh"
module dtl_bank (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire dtl_pkg::dtl_req_t req_in,
  output dtl_pkg::dtl_rsp_t rsp_out,
  input wire dtl_pkg::dtl_dpll_t dpll_in,
  output logic split_crystal_oscillator_out,
  output logic tie_discard_out,
  output logic tie_write_done_out,
  output logic [`DTL_PHASE_W-1:0] tie_thresh_ns_out,
  output logic [2*`DTL_DATA_W-1:0] lock_delay_out
);
  import dtl_pkg::*;
  // The bank answers every host access one cycle after taking it. Writes
  // land in the store at the taking edge; reads come back from a registered
  // port, so the answer and its data line up without extra staging.

  // Map an address to its register index, or flag it unmapped
  function automatic logic [`DTL_IDX_W:0] addr_to_idx(input logic [`DTL_ADDR_W-1:0] a);
    logic [`DTL_IDX_W:0] r;
    r = {1'b1, `DTL_IDX_SPLIT};
    unique case (a)
      `DTL_OFS_SPLIT: r = {1'b0, `DTL_IDX_SPLIT};
      `DTL_OFS_CLRSW: r = {1'b0, `DTL_IDX_CLRSW};
      `DTL_OFS_THRESH: r = {1'b0, `DTL_IDX_THRESH};
      `DTL_OFS_LOCKDLY: r = {1'b0, `DTL_IDX_LOCKDLY};
      `DTL_OFS_GUARD: r = {1'b0, `DTL_IDX_GUARD};
      default: r = {1'b1, `DTL_IDX_SPLIT};
    endcase
    return r;
  endfunction

  dtl_state_t state_q; // Answer pending
  dtl_state_t state_d;
  logic fail_q; // Last access failed
  logic fail_d;
  logic done_q; // Sticky TIE write done
  logic done_d;
  logic discard_q; // One-cycle TIE discard pulse
  logic discard_d;
  logic [`DTL_N_REGS*`DTL_DATA_W-1:0] regs_w; // All stored words
  logic [`DTL_DATA_W-1:0] mem_rdata_w; // Registered read of store
  logic [`DTL_DATA_W-1:0] lockdly_q; // Copy for squaring
  logic [2*`DTL_DATA_W-1:0] lock_sq_q; // Squared lock delay

  // Decode of the current request
  wire [`DTL_IDX_W:0] dec_w = addr_to_idx(req_in.addr);
  wire unmapped_w = dec_w[`DTL_IDX_W];
  wire [`DTL_IDX_W-1:0] idx_w = dec_w[`DTL_IDX_W-1:0];
  wire is_guard_w = (idx_w == `DTL_IDX_GUARD) && !unmapped_w;
  // Register fields
  wire [`DTL_DATA_W-1:0] split_w = regs_w[`DTL_IDX_SPLIT*`DTL_DATA_W +: `DTL_DATA_W];
  wire [`DTL_DATA_W-1:0] clrsw_w = regs_w[`DTL_IDX_CLRSW*`DTL_DATA_W +: `DTL_DATA_W];
  wire [`DTL_DATA_W-1:0] thresh_w = regs_w[`DTL_IDX_THRESH*`DTL_DATA_W +: `DTL_DATA_W];
  wire [`DTL_DATA_W-1:0] guard_w = regs_w[`DTL_IDX_GUARD*`DTL_DATA_W +: `DTL_DATA_W];
  wire lockout_w = guard_w[`DTL_BIT_LOCKOUT];
  // Lockout refuses writes to anything but the guard itself
  // The guard stays open so that the host can always unlock again
  wire blocked_w = lockout_w && !is_guard_w;
  wire bad_w = unmapped_w || (req_in.write && blocked_w);
  wire we_w = req_in.valid && req_in.write && !bad_w;
  // Only the lockout bit of the guard is writable; status is hardware owned
  wire [`DTL_DATA_W-1:0] wval_w = is_guard_w ?
    (req_in.wdata & (`DTL_DATA_W'(1) << `DTL_BIT_LOCKOUT)) : req_in.wdata;
  // Clear-on-switch is armed only with both enables set
  // The bank's own enable and the loop's clear bit are both needed
  wire clr_armed_w = clrsw_w[`DTL_BIT_EN] && dpll_in.tie_clear_bit;
  wire clr_event_w = clr_armed_w && (dpll_in.ref_switch || dpll_in.mode_to_ref);
  // Threshold in ns: code times step, zero means disabled
  wire [`DTL_PHASE_W-1:0] thresh_ns_w =
    `DTL_PHASE_W'(thresh_w) * `DTL_PHASE_W'(`DTL_THRESH_STEP_NS);
  wire thresh_on_w = (thresh_w != `DTL_RST_VAL);
  wire within_w = dpll_in.tie_write_active && (dpll_in.align_err_ns <= thresh_ns_w);
  wire guard_rd_w = req_in.valid && !req_in.write && is_guard_w;
  // Read or write aimed at a hole in the map
  wire bad_rd_w = req_in.valid && unmapped_w;
  // Lock-delay word as stored
  wire [`DTL_DATA_W-1:0] lockdly_w = regs_w[`DTL_IDX_LOCKDLY*`DTL_DATA_W +: `DTL_DATA_W];

  // Register store
  // One write port and one read port share the decoded index
  dtl_regmem u_mem (
    .clk_sys_in(clk_sys_in),
    .sys_rst_in(sys_rst_in),
    .we_in(we_w),
    .widx_in(idx_w),
    .wdata_in(wval_w),
    .ridx_in(idx_w),
    .rdata_out(mem_rdata_w),
    .all_out(regs_w)
  );

  // Next-state and flag logic
  always_comb begin
    // Hold by default; the discard pulse lasts one cycle
    state_d = state_q;
    fail_d = fail_q;
    done_d = done_q;
    discard_d = clr_event_w;
    // Answer follows every request by one cycle
    unique case (state_q)
      ST_IDLE: begin
        // Request taken, answer next cycle
        if (req_in.valid) begin
          state_d = ST_ANSWER;
        end
      end
      ST_ANSWER: begin
        // Back-to-back requests keep the answer up
        state_d = req_in.valid ? ST_ANSWER : ST_IDLE;
      end
    endcase
    // Each access records its own outcome
    if (req_in.valid) begin
      fail_d = bad_w;
    end
    // A fresh threshold restarts the completion watch
    if (we_w && idx_w == `DTL_IDX_THRESH) begin
      done_d = 1'b0;
    end
    // A discard throws the pending completion away too
    if (clr_event_w) begin
      done_d = 1'b0;
    end
    // Completion is tested last so it wins over both clears
    if (thresh_on_w && within_w) begin
      done_d = 1'b1;
    end
  end

  // State registers
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      state_q <= ST_IDLE;
      fail_q <= 1'b0;
      done_q <= 1'b0;
      discard_q <= 1'b0;
    end else begin
      state_q <= state_d;
      fail_q <= fail_d;
      done_q <= done_d;
      discard_q <= discard_d;
    end
  end

  // Lock delay squared, registered in two steps
  // The copy stage keeps the multiplier away from the store's write path,
  // so the square follows a write to the lock-delay word by two cycles.
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      // Delay word and square start at zero
      lockdly_q <= `DTL_RST_VAL;
      lock_sq_q <= '0;
    end else begin
      // Copy first, square the copy next
      lockdly_q <= lockdly_w;
      lock_sq_q <= (2*`DTL_DATA_W)'(lockdly_q) * (2*`DTL_DATA_W)'(lockdly_q);
    end
  end

  // Guard read bookkeeping
  // A status read reports the access that came before it. The read itself
  // always succeeds, so showing its own outcome would hide every failure.
  logic guard_rd_q; // Last read hit guard
  logic bad_rd_q; // Last access hit a hole
  logic stat_q; // Outcome shown in the status field
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      // Nothing read yet, no failure to show
      guard_rd_q <= 1'b0;
      bad_rd_q <= 1'b0;
      stat_q <= 1'b0;
    end else begin
      // Steer the next answer's read data
      guard_rd_q <= guard_rd_w;
      bad_rd_q <= bad_rd_w;
      // Freeze the previous outcome as the status read is taken
      if (guard_rd_w) begin
        stat_q <= fail_q;
      end
    end
  end

  // Status byte: lockout on top, failure flag at the bottom, zeros between
  wire [`DTL_DATA_W-1:0] status_w = {lockout_w, 6'h00, stat_q};

  // Answer one cycle after each request
  assign rsp_out.valid = (state_q == ST_ANSWER);
  // Outcome of the request just answered
  assign rsp_out.fail = fail_q;
  // Holes read as zero, the guard shows status, the rest come from the store
  assign rsp_out.rdata = bad_rd_q ? `DTL_RST_VAL : (guard_rd_q ? status_w : mem_rdata_w);

  // Split-crystal mode follows its enable bit and is off after reset
  assign split_crystal_oscillator_out = split_w[`DTL_BIT_EN];
  // One-cycle discard toward the TIE accumulator
  assign tie_discard_out = discard_q;
  // Sticky completion toward the write status
  assign tie_write_done_out = done_q;
  // Threshold in nanoseconds, zero when the watch is off
  assign tie_thresh_ns_out = thresh_ns_w;
  // Square of the lock-delay word
  assign lock_delay_out = lock_sq_q;
endmodule // dtl_bank

// file: test/dtl_bank_asserts.sv
// Port checks for the config bank.
// Assumes a bind onto dtl_bank and a single clock.
`timescale 1ns/1ns
`include "dtl_regs.svh"
module dtl_bank_asserts (
  input wire logic clk_sys_in,
  input wire logic sys_rst_in,
  input wire dtl_pkg::dtl_req_t req_in,
  input wire dtl_pkg::dtl_rsp_t rsp_out,
  input wire dtl_pkg::dtl_dpll_t dpll_in,
  input wire logic split_crystal_oscillator_out,
  input wire logic tie_discard_out,
  input wire logic tie_write_done_out,
  input wire logic [`DTL_PHASE_W-1:0] tie_thresh_ns_out,
  input wire logic [2*`DTL_DATA_W-1:0] lock_delay_out
);
  import dtl_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);
  // Address hits none of the five registers
  wire unmapped = !(req_in.addr inside {`DTL_OFS_SPLIT, `DTL_OFS_CLRSW, `DTL_OFS_THRESH,
    `DTL_OFS_LOCKDLY, `DTL_OFS_GUARD});
  // Write taken, then accepted or refused
  sequence s_wr(logic [`DTL_ADDR_W-1:0] a);
    req_in.valid && req_in.write && req_in.addr == a;
  endsequence
  sequence s_ok(logic [`DTL_ADDR_W-1:0] a);
    s_wr(a) ##1 !rsp_out.fail;
  endsequence
  AST_SPLIT: assert property (s_ok(`DTL_OFS_SPLIT) |->
    split_crystal_oscillator_out == $past(req_in.wdata[0]))
    else $error("split enable wrong");
  AST_BLOCK: assert property (s_wr(`DTL_OFS_THRESH) ##1 rsp_out.fail |-> $stable(tie_thresh_ns_out))
    else $error("refused write changed threshold");
  AST_THRESH: assert property (s_ok(`DTL_OFS_THRESH) |->
    tie_thresh_ns_out == 16'($past(req_in.wdata)) * 16'd10)
    else $error("threshold scale wrong");
  AST_LOCK: assert property (s_ok(`DTL_OFS_LOCKDLY) |-> ##2 lock_delay_out ==
    16'($past(req_in.wdata, 3)) * 16'($past(req_in.wdata, 3)))
    else $error("lock delay not squared");
  AST_UNMAPPED: assert property (req_in.valid && unmapped |=> rsp_out.fail && rsp_out.rdata == 8'h00)
    else $error("unmapped access not flagged");
  AST_OK: assert property (req_in.valid && !req_in.write && !unmapped |=> !rsp_out.fail)
    else $error("mapped read flagged");
  AST_ANSWER: assert property (req_in.valid |=> rsp_out.valid)
    else $error("no answer");
  AST_DISCARD: assert property (tie_discard_out |-> $past(dpll_in.tie_clear_bit) &&
    ($past(dpll_in.ref_switch) || $past(dpll_in.mode_to_ref)))
    else $error("discard without armed event");
  AST_DONE: assert property ($rose(tie_write_done_out) |->
    $past(tie_thresh_ns_out) != 16'h0000 && $past(dpll_in.tie_write_active) &&
    $past(dpll_in.align_err_ns) <= $past(tie_thresh_ns_out))
    else $error("done set without cause");
endmodule // dtl_bank_asserts

// file: test/dtl_host_model.sv
// Host side of the byte access port.
// Assumes the bank answers exactly one cycle after a request.
`timescale 1ns/1ns
`include "dtl_regs.svh"
module dtl_host_model (
  input wire logic clk_sys_in,
  output dtl_pkg::dtl_req_t req_out,
  input wire dtl_pkg::dtl_rsp_t rsp_in
);
  import dtl_pkg::*;
  // Idle request at time zero
  initial req_out = '0;
  // One byte access across one rising edge
  task automatic xfer(input logic w, input logic [`DTL_ADDR_W-1:0] a, input logic [`DTL_DATA_W-1:0] d,
    output logic [`DTL_DATA_W-1:0] rd, output logic f);
    @(negedge clk_sys_in);
    req_out = '{valid: 1'b1, write: w, addr: a, wdata: d};
    @(negedge clk_sys_in);
    // Released lines show the inverse, not a stale copy
    req_out = '{valid: 1'b0, write: ~w, addr: ~a, wdata: ~d};
    rd = rsp_in.rdata;
    f = rsp_in.fail;
  endtask
endmodule // dtl_host_model

// file: test/test_dpll_tie_lock_uport_config.sv
// Directed tests of the config bank.
// Assumes the host model drives the request port.
`timescale 1ns/1ns
`include "dtl_regs.svh"
module test_dpll_tie_lock_uport_config;
  import dtl_pkg::*;
  logic clk_sys_in = 1'b0;
  logic sys_rst_in = 1'b1;
  dtl_req_t req;
  dtl_rsp_t rsp;
  dtl_dpll_t dpll = '0;
  logic split, disc, done, fl;
  logic [15:0] thr, lck;
  logic [7:0] rdv;
  int bad_count = 0;
  int n_tests = 0;
  logic [11:0] ofs [5] = '{`DTL_OFS_SPLIT, `DTL_OFS_CLRSW, `DTL_OFS_THRESH, `DTL_OFS_LOCKDLY, `DTL_OFS_GUARD};
  // 4 ns clock
  always #2 clk_sys_in = ~clk_sys_in;
  dtl_bank i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req), .rsp_out(rsp),
    .dpll_in(dpll), .split_crystal_oscillator_out(split), .tie_discard_out(disc),
    .tie_write_done_out(done), .tie_thresh_ns_out(thr), .lock_delay_out(lck));
  dtl_host_model i_host (.clk_sys_in(clk_sys_in), .req_out(req), .rsp_in(rsp));
  // Compare and count
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // Write with expected refusal flag
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic ef);
    i_host.xfer(1'b1, a, d, rdv, fl);
    chk({15'h0, fl}, {15'h0, ef});
  endtask
  // Read with expected data and flag
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic ef);
    i_host.xfer(1'b0, a, 8'h00, rdv, fl);
    chk({7'h00, fl, rdv}, {7'h00, ef, e});
  endtask
  // Loop event pulse, discard looked at next cycle
  task automatic pulse(input logic sw, input logic md, input logic e);
    @(negedge clk_sys_in);
    dpll.ref_switch = sw;
    dpll.mode_to_ref = md;
    @(negedge clk_sys_in);
    dpll.ref_switch = 1'b0;
    dpll.mode_to_ref = 1'b0;
    chk({15'h0, disc}, {15'h0, e});
  endtask
  // Verdict
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Watchdog at 5000 cycles, far beyond the roughly 70 cycles needed
  initial begin
    #20000;
    bad_count++;
    conclude();
  end
  // Main sequence
  initial begin
    repeat (10) @(negedge clk_sys_in);
    sys_rst_in = 1'b0;
    foreach (ofs[i]) rd(ofs[i], 8'h00, 1'b0);
    chk({15'h0, split}, 16'h0000);
    $display("test reset done");
    wr(`DTL_OFS_THRESH, 8'h05, 1'b0);
    chk(thr, 16'd50);
    wr(`DTL_OFS_THRESH, 8'hff, 1'b0);
    chk(thr, 16'd2550);
    wr(`DTL_OFS_LOCKDLY, 8'hff, 1'b0);
    repeat (2) @(negedge clk_sys_in);
    chk(lck, 16'hfe01);
    $display("test values done");
    rd(12'h626, 8'h00, 1'b1);
    rd(`DTL_OFS_GUARD, 8'h01, 1'b0);
    rd(`DTL_OFS_GUARD, 8'h00, 1'b0);
    wr(`DTL_OFS_GUARD, 8'h80, 1'b0);
    wr(`DTL_OFS_SPLIT, 8'h01, 1'b1);
    wr(`DTL_OFS_THRESH, 8'h01, 1'b1);
    chk(thr, 16'd2550);
    rd(`DTL_OFS_GUARD, 8'h81, 1'b0);
    chk({15'h0, split}, 16'h0000);
    wr(`DTL_OFS_GUARD, 8'h00, 1'b0);
    wr(`DTL_OFS_SPLIT, 8'h01, 1'b0);
    chk({15'h0, split}, 16'h0001);
    wr(`DTL_OFS_SPLIT, 8'h00, 1'b0);
    chk({15'h0, split}, 16'h0000);
    $display("test guard done");
    wr(`DTL_OFS_CLRSW, 8'h01, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    dpll.tie_clear_bit = 1'b1;
    pulse(1'b1, 1'b0, 1'b1);
    pulse(1'b0, 1'b1, 1'b1);
    wr(`DTL_OFS_CLRSW, 8'h00, 1'b0);
    pulse(1'b1, 1'b0, 1'b0);
    $display("test discard done");
    wr(`DTL_OFS_THRESH, 8'h05, 1'b0);
    dpll.tie_write_active = 1'b1;
    dpll.align_err_ns = 16'd60;
    @(negedge clk_sys_in);
    chk({15'h0, done}, 16'h0000);
    dpll.align_err_ns = 16'd50;
    @(negedge clk_sys_in);
    chk({15'h0, done}, 16'h0001);
    dpll.tie_write_active = 1'b0;
    wr(`DTL_OFS_THRESH, 8'h00, 1'b0);
    dpll.tie_write_active = 1'b1;
    dpll.align_err_ns = 16'd0;
    repeat (2) @(negedge clk_sys_in);
    chk({15'h0, done}, 16'h0000);
    $display("test done flag done");
    conclude();
  end
endmodule // test_dpll_tie_lock_uport_config
bind dtl_bank dtl_bank_asserts i_chk (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .req_in(req_in),
  .rsp_out(rsp_out), .dpll_in(dpll_in), .split_crystal_oscillator_out(split_crystal_oscillator_out),
  .tie_discard_out(tie_discard_out), .tie_write_done_out(tie_write_done_out),
  .tie_thresh_ns_out(tie_thresh_ns_out), .lock_delay_out(lock_delay_out));
